// [src/rceb_defines.svh]
// Offsets, field positions, reset values and sizes of the receive channel enable bank
`ifndef RCEB_DEFINES_SVH
`define RCEB_DEFINES_SVH
`define RCEB_OFF_ENABLE_0   12'h000
`define RCEB_OFF_ENABLE_1   12'h004
`define RCEB_OFF_ENABLE_2   12'h008
`define RCEB_OFF_ENABLE_3   12'h00c
`define RCEB_OFF_CONTROL    12'h010
`define RCEB_OFF_STATUS     12'h014
`define RCEB_ENABLE_RESET   32'h0000_0000
`define RCEB_CTRL_RESET     32'h0000_0000
`define RCEB_CTRL_MCSEL     0
`define RCEB_CTRL_RX_ENH    1
`define RCEB_CTRL_TX_ENH    2
`define RCEB_CTRL_PABLK_LO  4
`define RCEB_CTRL_PBBLK_LO  6
`define RCEB_NUM_REGS       4
`define RCEB_NUM_CHANS      128
`define RCEB_HALF           16
`endif

// [src/rceb_pkg.sv]
// Types of the receive channel enable bank
package rceb_pkg;
  typedef enum logic [1:0] {
    RCEB_MODE_ALL    = 2'h0,
    RCEB_MODE_NORMAL = 2'h1,
    RCEB_MODE_ENH    = 2'h3,
    RCEB_MODE_MIXED  = 2'h2
  } rceb_mode_t;
  typedef logic [31:0] rceb_word_t;
endpackage : rceb_pkg

// [src/rceb_cfg_if.sv]
// Configuration carried from the register file to the channel mapper
`timescale 1ns/1ps
interface rceb_cfg_if;
  rceb_pkg::rceb_word_t        enable_word [4];
  logic                        rx_multichan_select;
  logic                        rx_enhanced_enable;
  logic                        tx_enhanced_enable;
  logic [1:0]                  rx_part_a_block_sel;
  logic [1:0]                  rx_part_b_block_sel;
  modport regs (output enable_word, rx_multichan_select, rx_enhanced_enable, tx_enhanced_enable,
                output rx_part_a_block_sel, rx_part_b_block_sel);
  modport map  (input enable_word, rx_multichan_select, rx_enhanced_enable, tx_enhanced_enable,
                input rx_part_a_block_sel, rx_part_b_block_sel);
endinterface : rceb_cfg_if

// [src/rceb_regs.sv]
// APB register file holding the four enable words and the multichannel control
`timescale 1ns/1ps
`include "rceb_defines.svh"
module rceb_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status from mapper
  input  wire logic [1:0]  mode_code,
  input  wire logic [7:0]  enabled_count,
  // Configuration out
  rceb_cfg_if.regs         cfg
);
  rceb_pkg::rceb_word_t enable_r [4];
  rceb_pkg::rceb_word_t enable_nxt [4];
  logic [31:0]          ctrl_r;
  logic [31:0]          ctrl_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic                 err_r;
  logic                 err_nxt;
  logic                 access;
  logic [31:0]          wmask;
  logic [31:0]          ctrl_mask;

  assign access    = psel && penable;
  assign pready    = 1'b1;
  assign prdata    = rdata_r;
  assign pslverr   = err_r;
  assign wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign ctrl_mask = 32'h0000_00f7;

  always_comb
  begin
    enable_nxt = enable_r;
    ctrl_nxt   = ctrl_r;
    rdata_nxt  = 32'h0000_0000;
    err_nxt    = 1'b0;
    // Response staged in setup so it stands for the whole access phase
    if (psel && !penable)
    begin
      case (paddr)
        `RCEB_OFF_ENABLE_0: rdata_nxt = enable_r[0];
        `RCEB_OFF_ENABLE_1: rdata_nxt = enable_r[1];
        `RCEB_OFF_ENABLE_2: rdata_nxt = enable_r[2];
        `RCEB_OFF_ENABLE_3: rdata_nxt = enable_r[3];
        `RCEB_OFF_CONTROL:  rdata_nxt = ctrl_r;
        `RCEB_OFF_STATUS:
        begin
          rdata_nxt = {22'h00_0000, mode_code, enabled_count};
          err_nxt   = pwrite;
        end
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          err_nxt   = 1'b1;
        end
      endcase
    end
    else if (access)
    begin
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      case (paddr)
        `RCEB_OFF_ENABLE_0, `RCEB_OFF_ENABLE_1, `RCEB_OFF_ENABLE_2, `RCEB_OFF_ENABLE_3:
        begin
          if (pwrite)
            enable_nxt[paddr[3:2]] = (enable_r[paddr[3:2]] & ~wmask) | (pwdata & wmask);
        end
        `RCEB_OFF_CONTROL:
        begin
          if (pwrite)
            ctrl_nxt = (ctrl_r & ~(wmask & ctrl_mask)) | (pwdata & wmask & ctrl_mask);
        end
        default:
        begin
          err_nxt = err_r;
        end
      endcase
    end
  end

  // Read data staged in setup, shown during access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r <= '{default: `RCEB_ENABLE_RESET};
      ctrl_r   <= `RCEB_CTRL_RESET;
      rdata_r  <= 32'h0000_0000;
      err_r    <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      ctrl_r   <= ctrl_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  assign cfg.enable_word         = enable_r;
  assign cfg.rx_multichan_select = ctrl_r[`RCEB_CTRL_MCSEL];
  assign cfg.rx_enhanced_enable  = ctrl_r[`RCEB_CTRL_RX_ENH];
  assign cfg.tx_enhanced_enable  = ctrl_r[`RCEB_CTRL_TX_ENH];
  assign cfg.rx_part_a_block_sel = ctrl_r[`RCEB_CTRL_PABLK_LO +: 2];
  assign cfg.rx_part_b_block_sel = ctrl_r[`RCEB_CTRL_PBBLK_LO +: 2];
endmodule : rceb_regs

// [src/rceb_map.sv]
// Channel map: turns enable words and mode into a per-channel receive enable
`timescale 1ns/1ps
`include "rceb_defines.svh"
module rceb_map (
  // Configuration in
  rceb_cfg_if.map        cfg,
  // Result
  output logic [127:0]   chan_mask,
  output logic [1:0]     mode_code
);
  logic                  enh;
  rceb_pkg::rceb_mode_t  mode;

  assign enh = cfg.rx_enhanced_enable && cfg.tx_enhanced_enable;

  always_comb
  begin
    if (!cfg.rx_multichan_select)
      mode = rceb_pkg::RCEB_MODE_ALL;
    else if (enh)
      mode = rceb_pkg::RCEB_MODE_ENH;
    else
      mode = rceb_pkg::RCEB_MODE_NORMAL;
  end
  assign mode_code = mode;

  genvar ch;
  generate
    for (ch = 0; ch < `RCEB_NUM_CHANS; ch = ch + 1)
    begin : g_chan
      localparam int BLK = ch / `RCEB_HALF;
      localparam int BIT = ch % `RCEB_HALF;
      logic sel_bit;
      always_comb
      begin
        case (mode)
          rceb_pkg::RCEB_MODE_ALL: sel_bit = 1'b1;
          rceb_pkg::RCEB_MODE_ENH: sel_bit = cfg.enable_word[ch / 32][ch % 32];
          rceb_pkg::RCEB_MODE_NORMAL:
          begin
            if ((BLK % 2) == 0)
              sel_bit = (cfg.rx_part_a_block_sel == 2'(BLK / 2)) && cfg.enable_word[0][BIT];
            else
              sel_bit = (cfg.rx_part_b_block_sel == 2'(BLK / 2)) && cfg.enable_word[0][16 + BIT];
          end
          default: sel_bit = 1'b0;
        endcase
      end
      assign chan_mask[ch] = sel_bit;
    end
  endgenerate
endmodule : rceb_map

// [src/rceb_top.sv]
// Receive channel enable bank: APB registers, channel map, selected-channel lookup
`timescale 1ns/1ps
`include "rceb_defines.svh"
module rceb_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receiver channel query
  input  wire logic [6:0]  rx_chan_num,
  output logic             rx_chan_enabled,
  output logic [127:0]     rx_chan_mask
);
  rceb_cfg_if            cfg ();
  logic [127:0]          mask_w;
  logic [1:0]            mode_w;
  logic [7:0]            count_r;
  logic [7:0]            count_nxt;
  logic [127:0]          mask_r;
  logic                  hit_r;
  logic                  hit_nxt;

  rceb_regs u_regs (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .mode_code     (mode_w),
    .enabled_count (count_r),
    .cfg           (cfg.regs)
  );

  rceb_map u_map (
    .cfg       (cfg.map),
    .chan_mask (mask_w),
    .mode_code (mode_w)
  );

  // Population count of enabled channels
  always_comb
  begin
    count_nxt = 8'h00;
    for (int i = 0; i < `RCEB_NUM_CHANS; i++)
      count_nxt = count_nxt + 8'(mask_w[i]);
    hit_nxt = mask_w[rx_chan_num];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= 8'h00;
      mask_r  <= 128'h0;
      hit_r   <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      mask_r  <= mask_w;
      hit_r   <= hit_nxt;
    end
  end

  assign rx_chan_mask    = mask_r;
  assign rx_chan_enabled = hit_r;

  a_off_all_on: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.rx_multichan_select |=> (rx_chan_mask == {128{1'b1}}))
    else $error("channels not all enabled with select clear");
  a_enh_linear: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.rx_multichan_select && cfg.rx_enhanced_enable && cfg.tx_enhanced_enable)
    |=> (rx_chan_mask == {$past(cfg.enable_word[3]), $past(cfg.enable_word[2]),
                          $past(cfg.enable_word[1]), $past(cfg.enable_word[0])}))
    else $error("enhanced mapping wrong");
  a_norm_part_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.rx_multichan_select && !(cfg.rx_enhanced_enable && cfg.tx_enhanced_enable))
    |=> (rx_chan_mask[$past(cfg.rx_part_a_block_sel) * 32 +: 16] == $past(cfg.enable_word[0][15:0])))
    else $error("partition A mapping wrong");
  a_norm_part_b: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.rx_multichan_select && !(cfg.rx_enhanced_enable && cfg.tx_enhanced_enable))
    |=> (rx_chan_mask[$past(cfg.rx_part_b_block_sel) * 32 + 16 +: 16] == $past(cfg.enable_word[0][31:16])))
    else $error("partition B mapping wrong");
  a_norm_count: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.rx_multichan_select && !(cfg.rx_enhanced_enable && cfg.tx_enhanced_enable))
    |=> (count_r <= 8'd32))
    else $error("normal mode enables over 32 channels");
  a_norm_only_w0: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.rx_multichan_select && !(cfg.rx_enhanced_enable && cfg.tx_enhanced_enable)
     && cfg.enable_word[0] == 32'h0) |=> (rx_chan_mask == 128'h0))
    else $error("normal mode uses more than first word");
  a_mode_select: assert property (@(posedge pclk) disable iff (!presetn)
    mode_w == {cfg.rx_multichan_select && cfg.rx_enhanced_enable && cfg.tx_enhanced_enable,
               cfg.rx_multichan_select})
    else $error("mode code wrong");
  a_query_hit: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (rx_chan_enabled == $past(mask_w[rx_chan_num])))
    else $error("channel query wrong");
  a_write_store: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == `RCEB_OFF_ENABLE_1 && pstrb == 4'hf)
    |=> (cfg.enable_word[1] == $past(pwdata)))
    else $error("enable word write lost");
endmodule : rceb_top

// [verif/tb.sv]
// Self-checking bench for the receive channel enable bank
`timescale 1ns/1ps
`include "rceb_defines.svh"
module tb;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [6:0]   rx_chan_num;
  logic         rx_chan_enabled;
  logic [127:0] rx_chan_mask;
  int           num_errors;
  int           checks_done;
  logic [31:0]  words [4];
  logic [31:0]  rd;
  logic         err;
  logic [127:0] exp_m;

  rceb_top i_dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .rx_chan_num     (rx_chan_num),
    .rx_chan_enabled (rx_chan_enabled),
    .rx_chan_mask    (rx_chan_mask)
  );

  always #10 pclk = ~pclk;

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // One APB transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Status word: mode code and count of enabled channels
  task automatic chk_status(input logic [1:0] md);
    apb(1'b0, `RCEB_OFF_STATUS, 32'h0);
    chk("status word", {118'h0, md, 8'($countones(exp_m))}, {96'h0, rd});
    chk("status error", 128'h0, {127'h0, err});
  endtask : chk_status

  // Expected per-channel enable from control and the four words
  function automatic logic [127:0] model(input logic [7:0] c);
    logic [127:0] m;
    m = '0;
    if (c[`RCEB_CTRL_MCSEL] == 1'b0)
      m = '1;
    else if (c[`RCEB_CTRL_RX_ENH] && c[`RCEB_CTRL_TX_ENH])
      m = {words[3], words[2], words[1], words[0]};
    else
      for (int b = 0; b < 16; b++)
      begin
        m[32 * c[5:4] + b]      = words[0][b];
        m[32 * c[7:6] + 16 + b] = words[0][16 + b];
      end
    return m;
  endfunction : model

  task automatic set_ctrl(input logic [7:0] c);
    apb(1'b1, `RCEB_OFF_CONTROL, {24'h000000, c});
    exp_m = model(c);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("channel mask", exp_m, rx_chan_mask);
  endtask : set_ctrl

  task automatic scan_chans;
    for (int ch = 0; ch < 128; ch++)
    begin
      @(posedge pclk);
      rx_chan_num <= 7'(ch);
      @(posedge pclk);
      @(negedge pclk);
      chk("channel enabled", {127'h0, exp_m[ch]}, {127'h0, rx_chan_enabled});
    end
  endtask : scan_chans

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    final_report();
  end

  initial
  begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    pstrb       = 4'hf;
    rx_chan_num = 7'h00;
    num_errors  = 0;
    checks_done = 0;
    words       = '{32'h8001_4003, 32'h1234_5678, 32'h0f0f_f0f0, 32'hdead_8001};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("mask after reset", '1, rx_chan_mask);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk("enable word reset", {96'h0, `RCEB_ENABLE_RESET}, {96'h0, rd});
    end
    for (int k = 0; k < 4; k++)
      apb(1'b1, 12'(4 * k), words[k]);
    pstrb    <= 4'h2;
    apb(1'b1, `RCEB_OFF_ENABLE_2, 32'hffff_ffff);
    pstrb    <= 4'hf;
    words[2] = words[2] | 32'h0000_ff00;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk("enable word readback", {96'h0, words[k]}, {96'h0, rd});
    end
    for (int v = 0; v < 4; v++)
      set_ctrl({2'(3 - v), 2'(v), 4'h1});
    scan_chans();
    chk_status(2'h1);
    set_ctrl(8'h03);
    set_ctrl(8'h05);
    set_ctrl(8'h07);
    scan_chans();
    words[3] = 32'h0000_0000;
    apb(1'b1, `RCEB_OFF_ENABLE_3, words[3]);
    set_ctrl(8'h07);
    chk_status(2'h3);
    set_ctrl(8'h00);
    chk_status(2'h0);
    apb(1'b1, `RCEB_OFF_STATUS, 32'hffff_ffff);
    chk("status write error", 128'h1, {127'h0, err});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 128'h1, {127'h0, err});
    chk("unmapped data", 128'h0, {96'h0, rd});
    final_report();
  end
endmodule : tb
